/* File: adc_ctrl_map.svh */
// register map, field positions and conversion timing counts of the converter control
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define OFF_INPUT_SELECT 12'h000
`define OFF_CONTROL_A 12'h004
`define OFF_CONTROL_B 12'h008
`define OFF_RESULT_LOW 12'h00C
`define OFF_RESULT_HIGH 12'h010
`define BIT_ENABLE 7
`define BIT_START 6
`define BIT_AUTO 5
`define BIT_FLAG 4
`define BIT_LEFT_ADJUST 4
`define TEMP_SENSOR_CODE 6'h22
`define DIFF_FIRST_CODE 6'h08
`define CYC_NORMAL 5'h0D
`define CYC_FIRST 5'h19
`define CYC_AUTO 5'h0D
`define SH_NORMAL 5'h01
`define SH_FIRST 5'h0E
`define SH_AUTO 5'h02
`define SYNC_CYCLES 3
`endif

/* File: adc_ctrl_pkg.sv */
// types shared by the converter control modules
package adc_ctrl_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_CONV = 2'h2} conv_state_e;
  typedef enum logic [1:0] {REF_SUPPLY = 2'h0, REF_EXT_PIN = 2'h1, REF_INT_1V1 = 2'h2} ref_sel_e;
endpackage

/* File: adc_prescaler.sv */
// converter clock prescaler producing rising and falling edge enables
`timescale 1ns/100ps
module adc_prescaler
  import adc_ctrl_pkg::*;
#(
  parameter int DIV_BASE = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic restart,
  input wire logic [2:0] div_sel,
  output logic rise_tick,
  output logic fall_tick
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [8:0] div;

  always_comb
  begin
    div = 9'(DIV_BASE << div_sel);
    rise_tick = enable && !restart && ({1'b0, cnt_reg} == div - 9'h1);
    fall_tick = enable && !restart && ({1'b0, cnt_reg} == (div >> 1) - 9'h1);
    if (!enable || restart || rise_tick)
    begin
      cnt_next = 8'h00;
    end
    else
    begin
      cnt_next = cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 8'h00;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  property p_held_when_off;
    @(posedge pclk) disable iff (!presetn)
    !enable [*2] |-> cnt_reg == 8'h00 && !rise_tick;
  endproperty
  a_held_when_off: assert property (p_held_when_off) else $error("prescaler ran while off");
endmodule

/* File: sar_adc_conversion_control.sv */
// successive approximation converter control: registers, sequencing and result locking
//
// Overview of operation
// - result is a 10-bit code, zero at ground, full scale at reference.
// - reference field picks supply, external reference pin or internal 1.1V.
// - channel field picks single-ended (no gain) or differential; low bit picks 1x/20x.
// - channel code 100010 routes the temperature sensor.
// - reference and channel selections act only while the enable bit is set.
// - prescaler runs while enabled and is held in reset while disabled.
// - result is right-aligned by default, left-aligned when left adjust is set.
// - low byte read locks both result bytes until high byte read.
// - completion flag still sets when a locked result is discarded.
// - writing start begins a conversion; bit stays one until hardware clears it.
// - channel change during conversion applies only after it finishes.
// - auto-trigger rising edge resets the prescaler and starts a conversion.
// - trigger edges during conversion are ignored; a held level does not restart.
// - flag-type trigger sources must be cleared before they trigger again.
// - completion flag as trigger converts continuously; first start by software.
// - start bit launches single conversion in auto mode, reads one while busy.
// - software start begins at the next prescaled clock rising edge.
// - normal conversion 13 converter cycles, first after enable 25.
// - sample-and-hold at 1.5 cycles normally, 14.5 on the first conversion.
// - at completion write result, set flag, clear start in single mode.
// - auto-triggered sample at 2 cycles, total 13.5, plus 3 clock synchronisation.
// - free-running mode restarts immediately after completion, start bit kept high.
// - selections track a buffer, frozen during conversion, tracking in last cycle.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "adc_ctrl_map.svh"
module sar_adc_conversion_control
  import adc_ctrl_pkg::*;
#(
  parameter int PRESCALE_BASE = 2,
  parameter logic [2:0] TRIG_SELF_CODE = 3'h0,
  parameter int TRIG_WIDTH = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TRIG_WIDTH-1:0] trigger_sources,
  input wire logic [9:0] sar_code,
  output logic [1:0] reference_select,
  output logic [5:0] channel_select,
  output logic differential_mode,
  output logic gain_20x,
  output logic temp_sensor_select,
  output logic analog_enable,
  output logic sample_hold,
  output logic conversion_busy
);
  ////////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] input_select_register_reg;
  logic [7:0] input_select_register_next;
  logic converter_enable_reg;
  logic converter_enable_next;
  logic auto_trigger_enable_reg;
  logic auto_trigger_enable_next;
  logic conversion_complete_flag_reg;
  logic conversion_complete_flag_next;
  logic [2:0] prescaler_select_reg;
  logic [2:0] prescaler_select_next;
  logic left_adjust_reg;
  logic left_adjust_next;
  logic [2:0] trigger_select_reg;
  logic [2:0] trigger_select_next;
  logic [9:0] result_reg;
  logic [9:0] result_next;
  logic lock_reg;
  logic lock_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  // sequencer state
  conv_state_e state_reg;
  conv_state_e state_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic first_reg;
  logic first_next;
  logic auto_reg;
  logic auto_next;
  logic pending_reg;
  logic pending_next;
  logic [7:0] active_sel_reg;
  logic [7:0] active_sel_next;
  logic trig_prev_reg;
  logic [`SYNC_CYCLES-1:0] trig_pipe_reg;
  logic [`SYNC_CYCLES-1:0] trig_pipe_next;
  logic sample_hold_reg;
  logic sample_hold_next;
  // combinational terms
  logic rise_tick;
  logic fall_tick;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [7:0] low_byte;
  logic [7:0] high_byte;
  logic trig_level;
  logic trig_go;
  logic free_run;
  logic done;
  logic track;
  logic sh_hit;
  logic [4:0] last_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // prescaled converter clock
  adc_prescaler #(
    .DIV_BASE(PRESCALE_BASE)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .enable(converter_enable_reg),
    .restart(trig_go),
    .div_sel(prescaler_select_reg),
    .rise_tick(rise_tick),
    .fall_tick(fall_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: read data captured in first access cycle, pready and write data in the second
  always_comb
  begin
    mapped = paddr == `OFF_INPUT_SELECT || paddr == `OFF_CONTROL_A || paddr == `OFF_CONTROL_B
      || paddr == `OFF_RESULT_LOW || paddr == `OFF_RESULT_HIGH;
    wr_en = psel && penable && pready_reg && pwrite && mapped;
    rd_en = psel && penable && !pready_reg && !pwrite;
    pready_next = psel && penable && !pready_reg;
    pslverr_next = psel && penable && !pready_reg && !mapped;
    if (left_adjust_reg)
    begin
      high_byte = result_reg[9:2];
      low_byte = {result_reg[1:0], 6'h00};
    end
    else
    begin
      high_byte = {6'h00, result_reg[9:8]};
      low_byte = result_reg[7:0];
    end
    prdata_next = prdata_reg;
    if (rd_en)
    begin
      case (paddr)
        `OFF_INPUT_SELECT: prdata_next = {24'h00_0000, input_select_register_reg};
        `OFF_CONTROL_A: prdata_next = {24'h00_0000, converter_enable_reg,
          state_reg == ST_CONV || pending_reg, auto_trigger_enable_reg,
          conversion_complete_flag_reg, 1'b0, prescaler_select_reg};
        `OFF_CONTROL_B: prdata_next = {24'h00_0000, 3'h0, left_adjust_reg, 1'b0,
          trigger_select_reg};
        `OFF_RESULT_LOW: prdata_next = {24'h00_0000, low_byte};
        `OFF_RESULT_HIGH: prdata_next = {24'h00_0000, high_byte};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger edge detection and synchronisation delay
  always_comb
  begin
    free_run = auto_trigger_enable_reg && trigger_select_reg == TRIG_SELF_CODE;
    if (trigger_select_reg == TRIG_SELF_CODE)
    begin
      trig_level = conversion_complete_flag_reg;
    end
    else
    begin
      trig_level = trigger_sources[trigger_select_reg];
    end
    trig_pipe_next = {trig_pipe_reg[`SYNC_CYCLES-2:0], trig_level && !trig_prev_reg};
    trig_go = trig_pipe_reg[`SYNC_CYCLES-1] && auto_trigger_enable_reg && !free_run
      && converter_enable_reg && state_reg == ST_IDLE && !pending_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  always_comb
  begin
    if (first_reg)
    begin
      last_cnt = `CYC_FIRST - 5'h01;
      sh_hit = fall_tick && cnt_reg == `SH_FIRST;
      done = rise_tick && cnt_reg == last_cnt;
    end
    else if (auto_reg)
    begin
      last_cnt = `CYC_AUTO;
      sh_hit = rise_tick && cnt_reg == `SH_AUTO - 5'h01;
      done = fall_tick && cnt_reg == last_cnt;
    end
    else
    begin
      last_cnt = `CYC_NORMAL - 5'h01;
      sh_hit = fall_tick && cnt_reg == `SH_NORMAL;
      done = rise_tick && cnt_reg == last_cnt;
    end
    done = done && state_reg == ST_CONV;
    sample_hold_next = sh_hit && state_reg == ST_CONV;
    track = state_reg == ST_IDLE || cnt_reg == last_cnt;
    state_next = state_reg;
    cnt_next = cnt_reg;
    first_next = first_reg;
    auto_next = auto_reg;
    pending_next = pending_reg;
    if (state_reg == ST_CONV && (rise_tick || fall_tick) && !done)
    begin
      cnt_next = rise_tick ? cnt_reg + 5'h01 : cnt_reg;
    end
    if (wr_en && paddr == `OFF_CONTROL_A && pwdata[`BIT_START] && state_reg == ST_IDLE)
    begin
      pending_next = 1'b1;
    end
    case (state_reg)
      ST_IDLE:
      begin
        if (trig_go)
        begin
          state_next = ST_CONV;
          cnt_next = 5'h00;
          auto_next = 1'b1;
          pending_next = 1'b0;
        end
        else if (pending_reg && rise_tick)
        begin
          state_next = ST_CONV;
          cnt_next = 5'h00;
          auto_next = 1'b0;
          pending_next = 1'b0;
        end
      end
      ST_CONV:
      begin
        if (done)
        begin
          first_next = 1'b0;
          auto_next = 1'b0;
          cnt_next = 5'h00;
          state_next = free_run ? ST_CONV : ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (!converter_enable_reg)
    begin
      state_next = ST_IDLE;
      // a start written together with the enable bit is kept
      pending_next = pending_next && converter_enable_next;
      first_next = 1'b1;
      cnt_next = 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers, flag, result and lock
  always_comb
  begin
    input_select_register_next = input_select_register_reg;
    converter_enable_next = converter_enable_reg;
    auto_trigger_enable_next = auto_trigger_enable_reg;
    prescaler_select_next = prescaler_select_reg;
    left_adjust_next = left_adjust_reg;
    trigger_select_next = trigger_select_reg;
    conversion_complete_flag_next = conversion_complete_flag_reg;
    result_next = result_reg;
    lock_next = lock_reg;
    if (wr_en && paddr == `OFF_INPUT_SELECT)
    begin
      input_select_register_next = pwdata[7:0];
    end
    if (wr_en && paddr == `OFF_CONTROL_A)
    begin
      converter_enable_next = pwdata[`BIT_ENABLE];
      auto_trigger_enable_next = pwdata[`BIT_AUTO];
      prescaler_select_next = pwdata[2:0];
      if (pwdata[`BIT_FLAG])
      begin
        conversion_complete_flag_next = 1'b0;
      end
    end
    if (wr_en && paddr == `OFF_CONTROL_B)
    begin
      left_adjust_next = pwdata[`BIT_LEFT_ADJUST];
      trigger_select_next = pwdata[2:0];
    end
    if (rd_en && paddr == `OFF_RESULT_LOW)
    begin
      lock_next = 1'b1;
    end
    if (rd_en && paddr == `OFF_RESULT_HIGH)
    begin
      lock_next = 1'b0;
    end
    if (done)
    begin
      conversion_complete_flag_next = 1'b1;
      if (!lock_reg)
      begin
        result_next = sar_code;
      end
    end
    active_sel_next = track ? input_select_register_reg : active_sel_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_select_register_reg <= 8'h00;
      converter_enable_reg <= 1'b0;
      auto_trigger_enable_reg <= 1'b0;
      conversion_complete_flag_reg <= 1'b0;
      prescaler_select_reg <= 3'h0;
      left_adjust_reg <= 1'b0;
      trigger_select_reg <= 3'h0;
      result_reg <= 10'h000;
      lock_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      first_reg <= 1'b1;
      auto_reg <= 1'b0;
      pending_reg <= 1'b0;
      active_sel_reg <= 8'h00;
      trig_prev_reg <= 1'b0;
      trig_pipe_reg <= '0;
      sample_hold_reg <= 1'b0;
    end
    else
    begin
      input_select_register_reg <= input_select_register_next;
      converter_enable_reg <= converter_enable_next;
      auto_trigger_enable_reg <= auto_trigger_enable_next;
      conversion_complete_flag_reg <= conversion_complete_flag_next;
      prescaler_select_reg <= prescaler_select_next;
      left_adjust_reg <= left_adjust_next;
      trigger_select_reg <= trigger_select_next;
      result_reg <= result_next;
      lock_reg <= lock_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      first_reg <= first_next;
      auto_reg <= auto_next;
      pending_reg <= pending_next;
      active_sel_reg <= active_sel_next;
      trig_prev_reg <= trig_level;
      trig_pipe_reg <= trig_pipe_next;
      sample_hold_reg <= sample_hold_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the analog front end, selections and modes gated by the enable bit
  always_comb
  begin
    prdata = prdata_reg;
    pready = pready_reg;
    pslverr = pslverr_reg;
    analog_enable = converter_enable_reg;
    reference_select = converter_enable_reg ? active_sel_reg[7:6] : 2'h0;
    channel_select = converter_enable_reg ? active_sel_reg[5:0] : 6'h00;
    temp_sensor_select = converter_enable_reg && active_sel_reg[5:0] == `TEMP_SENSOR_CODE;
    differential_mode = converter_enable_reg && !temp_sensor_select
      && active_sel_reg[5:0] >= `DIFF_FIRST_CODE;
    gain_20x = differential_mode && active_sel_reg[0];
    sample_hold = sample_hold_reg;
    conversion_busy = state_reg == ST_CONV;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_locked_result;
    @(posedge pclk) disable iff (!presetn)
    lock_reg && done |=> $stable(result_reg);
  endproperty
  a_locked_result: assert property (p_locked_result) else $error("locked result changed");

  property p_flag_on_done;
    @(posedge pclk) disable iff (!presetn)
    done |=> conversion_complete_flag_reg;
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("flag not set at completion");

  property p_single_ends;
    @(posedge pclk) disable iff (!presetn)
    done && !free_run && !trig_go |=> state_reg == ST_IDLE;
  endproperty
  a_single_ends: assert property (p_single_ends) else $error("single conversion kept running");

  property p_free_run;
    @(posedge pclk) disable iff (!presetn)
    done && free_run && converter_enable_reg |=> state_reg == ST_CONV && cnt_reg == 5'h00;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free running did not restart");

  property p_trig_ignored;
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_CONV |-> !trig_go;
  endproperty
  a_trig_ignored: assert property (p_trig_ignored) else $error("trigger taken while busy");

  property p_start_on_edge;
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_IDLE && pending_reg && converter_enable_reg && !rise_tick && !trig_go
      |=> state_reg == ST_IDLE;
  endproperty
  a_start_on_edge: assert property (p_start_on_edge) else $error("started off clock edge");

  property p_frozen_select;
    @(posedge pclk) disable iff (!presetn)
    state_reg == ST_CONV && !track |=> $stable(active_sel_reg);
  endproperty
  a_frozen_select: assert property (p_frozen_select) else $error("selection moved mid conversion");

  property p_normal_length;
    @(posedge pclk) disable iff (!presetn)
    done && !first_reg && !auto_reg |-> cnt_reg == 5'h0C;
  endproperty
  a_normal_length: assert property (p_normal_length) else $error("normal length wrong");

  property p_gated_off;
    @(posedge pclk) disable iff (!presetn)
    !converter_enable_reg |-> channel_select == 6'h00 && !gain_20x ##1 state_reg == ST_IDLE;
  endproperty
  a_gated_off: assert property (p_gated_off) else $error("selection active while disabled");
endmodule

/* File: adc_front_end_model.sv */
// behavioural analog front end: holds the sampled input code for the converter control
`timescale 1ns/100ps
module adc_front_end_model
(
  input wire logic pclk,
  input wire logic [1:0] reference_select,
  input wire logic [5:0] channel_select,
  input wire logic analog_enable,
  input wire logic sample_hold,
  output logic [9:0] sar_code
);
  initial sar_code = 10'h000;
  // code encodes the frozen selection so a wrong channel shows in the result
  always @(posedge pclk)
  begin
    if (analog_enable !== 1'b1)
    begin
      sar_code <= ~sar_code;
    end
    else if (sample_hold === 1'b1)
    begin
      sar_code <= {reference_select, 2'h1, channel_select};
    end
  end
endmodule

/* File: sar_adc_conversion_control_bench.sv */
// self-checking bench for the converter control with an analog front end model
`timescale 1ns/100ps
`include "adc_ctrl_map.svh"
module sar_adc_conversion_control_bench
  import adc_ctrl_pkg::*;
;
  localparam int DIV = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] trigger_sources;
  logic [9:0] sar_code;
  logic [1:0] reference_select, rf;
  logic [5:0] channel_select, ch, chb;
  logic differential_mode, gain_20x, temp_sensor_select, analog_enable, sample_hold;
  logic conversion_busy;
  logic [15:0] res;
  int n_mismatch, checks_done, cyc, seed, n, busy_run, last_run, sh_total, sh0;
  sar_adc_conversion_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_sources(trigger_sources), .sar_code(sar_code),
    .reference_select(reference_select), .channel_select(channel_select),
    .differential_mode(differential_mode), .gain_20x(gain_20x),
    .temp_sensor_select(temp_sensor_select), .analog_enable(analog_enable),
    .sample_hold(sample_hold), .conversion_busy(conversion_busy));
  adc_front_end_model u_front (.pclk(pclk), .reference_select(reference_select),
    .channel_select(channel_select), .analog_enable(analog_enable),
    .sample_hold(sample_hold), .sar_code(sar_code));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    sh_total <= sh_total + (sample_hold === 1'b1);
    if (conversion_busy === 1'b1)
    begin
      busy_run <= busy_run + 1;
    end
    else if (busy_run != 0)
    begin
      last_run <= busy_run;
      busy_run <= 0;
    end
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    check(k < 20, 1, "apb answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    n = 0;
    while (conversion_busy !== lvl && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    check(n < lim, 1, "busy wait");
  endtask
  function automatic logic [31:0] ctl(input logic en, input logic st, input logic au,
                                      input logic fl);
    return {24'h00_0000, en, st, au, fl, 4'h1};
  endfunction
  function automatic logic [15:0] exp_res(input logic [5:0] c, input logic [1:0] r,
                                          input logic la);
    logic [9:0] v;
    v = {r, 2'h1, c};
    return la ? {v[9:2], v[1:0], 6'h00} : {6'h00, v[9:8], v[7:0]};
  endfunction
  task automatic read_res;
    apb(1'b0, `OFF_RESULT_LOW, 32'h0000_0000);
    res[7:0] = rd[7:0];
    apb(1'b0, `OFF_RESULT_HIGH, 32'h0000_0000);
    res[15:8] = rd[7:0];
  endtask
  task automatic start_conv;
    apb(1'b1, `OFF_CONTROL_A, ctl(1'b1, 1'b1, 1'b0, 1'b0));
    wait_busy(1'b1, DIV + 4);
    apb(1'b0, `OFF_CONTROL_A, 32'h0000_0000);
    check(rd[6], 1, "start bit while busy");
  endtask
  task automatic finish_conv(input int cyc_n, input int extra);
    wait_busy(1'b0, 30 * DIV);
    @(posedge pclk);
    check(last_run >= (cyc_n - 1) * DIV - 1 && last_run <= cyc_n * DIV + 1 + extra, 1,
          "conversion length");
    apb(1'b0, `OFF_CONTROL_A, 32'h0000_0000);
    // runs with a sync allowance are auto-triggered and keep auto mode on
    check(rd[7:4], {2'b10, extra != 0, 1'b1}, "start cleared, flag set");
    apb(1'b1, `OFF_CONTROL_A, ctl(1'b1, 1'b0, extra != 0, 1'b1));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 18;
    {presetn, psel, penable, pwrite, paddr, pwdata, trigger_sources} = '0;
    {cyc, n_mismatch, checks_done, busy_run, last_run, sh_total} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 5; a++)
    begin
      apb(1'b0, 12'(a * 4), 32'h0000_0000);
      check(rd, 0, "reset value");
    end
    apb(1'b0, 12'h014, 32'h0000_0000);
    check(err, 1, "unmapped error");
    check(rd, 0, "unmapped read");
    apb(1'b1, `OFF_CONTROL_A, ctl(1'b1, 1'b0, 1'b0, 1'b0));
    for (int i = 0; i < 9; i++)
    begin
      ch = (i == 0) ? 6'h22 : (i == 1) ? 6'h08 : (i == 2) ? 6'h07 : 6'($random(seed));
      rf = 2'($unsigned($random(seed)) % 3);
      apb(1'b1, `OFF_INPUT_SELECT, {24'h00_0000, rf, ch});
      // the tracking buffer takes the new selection one clock after the write
      @(posedge pclk);
      check({reference_select, channel_select}, {rf, ch}, "selection");
      check(differential_mode, ch >= 6'h08 && ch != 6'h22, "differential");
      check(gain_20x, ch >= 6'h08 && ch != 6'h22 && ch[0], "gain");
      check(temp_sensor_select, ch == 6'h22, "temperature");
    end
    apb(1'b1, `OFF_CONTROL_A, ctl(1'b0, 1'b0, 1'b0, 1'b0));
    check({analog_enable, reference_select, channel_select}, 0, "disabled");
    ch = 6'($random(seed));
    chb = ~ch;
    apb(1'b1, `OFF_INPUT_SELECT, {24'h00_0000, 2'h1, ch});
    start_conv();
    finish_conv(25, 0);
    read_res();
    check(res, exp_res(ch, 2'h1, 1'b0), "right aligned result");
    start_conv();
    apb(1'b1, `OFF_INPUT_SELECT, {24'h00_0000, 2'h1, chb});
    check(channel_select, ch, "frozen channel");
    finish_conv(13, 0);
    check(channel_select, chb, "new channel applied");
    read_res();
    check(res, exp_res(ch, 2'h1, 1'b0), "old channel result");
    apb(1'b1, `OFF_CONTROL_B, 32'h0000_0010);
    apb(1'b0, `OFF_RESULT_LOW, 32'h0000_0000);
    start_conv();
    finish_conv(13, 0);
    apb(1'b0, `OFF_RESULT_HIGH, 32'h0000_0000);
    check(rd[7:0], exp_res(ch, 2'h1, 1'b1) >> 8, "locked high byte");
    start_conv();
    finish_conv(13, 0);
    read_res();
    check(res, exp_res(chb, 2'h1, 1'b1), "left aligned result");
    apb(1'b1, `OFF_CONTROL_B, 32'h0000_0011);
    apb(1'b1, `OFF_CONTROL_A, ctl(1'b1, 1'b0, 1'b1, 1'b0));
    trigger_sources <= 8'h02;
    wait_busy(1'b1, 2 * DIV + 8);
    repeat (8) @(posedge pclk);
    trigger_sources <= 8'h00;
    repeat (2) @(posedge pclk);
    trigger_sources <= 8'h02;
    finish_conv(14, 4);
    repeat (30) @(posedge pclk);
    check(conversion_busy, 0, "held trigger level");
    trigger_sources <= 8'h00;
    repeat (2) @(posedge pclk);
    trigger_sources <= 8'h02;
    wait_busy(1'b1, 2 * DIV + 8);
    finish_conv(14, 4);
    trigger_sources <= 8'h00;
    apb(1'b1, `OFF_CONTROL_B, 32'h0000_0010);
    sh0 = sh_total;
    apb(1'b1, `OFF_CONTROL_A, ctl(1'b1, 1'b1, 1'b1, 1'b0));
    repeat (40 * DIV) @(posedge pclk);
    apb(1'b0, `OFF_CONTROL_A, 32'h0000_0000);
    check(rd[6], 1, "start kept in free run");
    check(sh_total - sh0 >= 3, 1, "continuous conversions");
    apb(1'b1, `OFF_CONTROL_A, ctl(1'b1, 1'b0, 1'b0, 1'b0));
    wait_busy(1'b0, 30 * DIV);
    repeat (2) @(posedge pclk);
    apb(1'b0, `OFF_CONTROL_A, 32'h0000_0000);
    check(rd[6], 0, "free run stopped");
    print_verdict();
  end
endmodule
